/* design/zwf_counter.sv */
// Purpose: weighted leaky zero counter, saturating at the flag threshold
// Assumes: step is a one-cycle pulse per conversion cycle
// Notes:   hit_o is combinational and marks the step that reaches the limit

`timescale 1ns/100ps
`default_nettype none

module zwf_counter
  import zwf_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       step_i,
  input  wire logic       any_zero_i,
  input  wire logic       hold_i,
  input  wire logic [3:0] weight_i,
  output logic      [3:0] count_o,
  output logic            hit_o
);

  logic [3:0] count_reg;
  logic [3:0] count_next;

  // ----------------------------------------------------------------
  // saturating add, kept at 4 bits so the limit is never passed
  // ----------------------------------------------------------------
  function automatic logic [3:0] sat_add(input logic [3:0] a, input logic [3:0] b);
    logic [4:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = (s > {1'b0, ZWF_CNT_LIMIT}) ? ZWF_CNT_LIMIT : s[3:0];
  endfunction

  // next count: hold clears, weight on zero steps, minus one on other steps until zero
  always_comb begin
    count_next = count_reg;
    if (hold_i) begin
      count_next = ZWF_CNT_RST;
    end else if (step_i && any_zero_i) begin
      count_next = sat_add(count_reg, weight_i);
    end else if (step_i && (count_reg != ZWF_CNT_RST)) begin
      count_next = count_reg - 4'h1;
    end
  end

  // reaching the limit on this step raises the flag upstream
  assign hit_o = !hold_i && step_i && any_zero_i && (weight_i != 4'h0)
                 && (count_next == ZWF_CNT_LIMIT);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_reg <= ZWF_CNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count_o = count_reg;

endmodule

`default_nettype wire

/* design/zwf_top.sv */
// Purpose: zero reading weight filter with its config and status bits
// Assumes: register requests and conversion results are synchronous pulses
// Notes:   only bit 3 of the status byte belongs here; other bits read zero

`timescale 1ns/100ps
`default_nettype none

module zwf_top
  import zwf_pkg::*;
(
  input  wire logic                  REF_CLK_I,
  input  wire logic                  RSTN_I,
  input  wire logic                  NORMAL_OP_I,
  input  wire zwf_pkg::zwf_conv_t    CONV_I,
  input  wire zwf_pkg::zwf_reg_req_t REG_I,
  input  wire zwf_pkg::zwf_ctl_t     CTL_I,
  output logic                [7:0]  RD_DATA_O,
  output logic                       RD_VALID_O,
  output logic                       ZERO_FLAG_O,
  output logic                       CALIB_IRQ_O,
  output logic                [3:0]  ZERO_COUNT_O
);

  import zwf_pkg::*;

  logic [3:0] weight_reg;
  logic       flag_reg;
  logic       irq_reg;
  logic [7:0] rd_data_reg;
  logic       rd_valid_reg;
  logic       any_zero;
  logic       auto_on;
  logic       step;
  logic       hit;
  logic       flag_clr;
  logic [3:0] count;

  // ----------------------------------------------------------------
  // conversion qualification
  // ----------------------------------------------------------------

  // any of the four channels reading exactly zero
  always_comb begin
    any_zero = 1'b0;
    for (int i = 0; i < ZWF_NCH; i++) begin
      if (CONV_I.ch[i] == '0) begin
        any_zero = 1'b1;
      end
    end
  end

  // automatic offset fixing makes the zero count meaningless, so clear it to zero
  assign auto_on = CTL_I.avg_auto_offset_fix || CTL_I.near_auto_offset_fix;
  assign step    = CONV_I.valid && NORMAL_OP_I;
  assign flag_clr = REG_I.wr && (REG_I.addr == ZWF_STAT_ADDR)
                    && REG_I.wdata[ZWF_ZFLAG_BIT];

  zwf_counter u_counter (
    .clk_i      (REF_CLK_I),
    .rstn_i     (RSTN_I),
    .step_i     (step),
    .any_zero_i (any_zero),
    .hold_i     (auto_on),
    .weight_i   (weight_reg),
    .count_o    (count),
    .hit_o      (hit)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // weight field; reserved upper bits are dropped on write
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      weight_reg <= ZWF_WEIGHT_RST;
    end else if (REG_I.wr && (REG_I.addr == ZWF_CFG3_ADDR)) begin
      weight_reg <= REG_I.wdata[ZWF_WEIGHT_LSB +: ZWF_WEIGHT_W];
    end
  end

  // sticky flag; a hit in the clearing cycle wins so no event is lost
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      flag_reg <= 1'b0;
    end else if (hit) begin
      flag_reg <= 1'b1;
    end else if (flag_clr) begin
      flag_reg <= 1'b0;
    end
  end

  // interrupt follows the flag one cycle later, gated by its enable
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= flag_reg && CTL_I.calib_irq_enable;
    end
  end

  // read path, one cycle latency; unmapped addresses read zero
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rd_data_reg  <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= REG_I.rd;
      if (!REG_I.rd) begin
        rd_data_reg <= 8'h00;
      end else if (REG_I.addr == ZWF_CFG3_ADDR) begin
        rd_data_reg <= {4'h0, weight_reg};
      end else if (REG_I.addr == ZWF_STAT_ADDR) begin
        rd_data_reg <= 8'(flag_reg) << ZWF_ZFLAG_BIT;
      end else begin
        rd_data_reg <= 8'h00;
      end
    end
  end

  assign RD_DATA_O    = rd_data_reg;
  assign RD_VALID_O   = rd_valid_reg;
  assign ZERO_FLAG_O  = flag_reg;
  assign CALIB_IRQ_O  = irq_reg;
  assign ZERO_COUNT_O = count;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  weight_write_a: assert property (
    REG_I.wr && REG_I.addr == ZWF_CFG3_ADDR |=> weight_reg == $past(REG_I.wdata[3:0])
  ) else $error("weight field not taken from write");

  count_add_a: assert property (
    step && any_zero && !auto_on |=>
      count == (($past(count) + $past(weight_reg) > 15) ? 4'hf
                : 4'($past(count) + $past(weight_reg)))
  ) else $error("zero cycle did not add weight");

  count_dec_a: assert property (
    step && !any_zero && !auto_on && count != 4'h0 |=> count == $past(count) - 4'h1
  ) else $error("clean cycle did not decrement");

  flag_raise_a: assert property (
    !auto_on ##1 $rose(count == ZWF_CNT_LIMIT) |-> flag_reg
  ) else $error("flag not raised at limit");

  auto_hold_a: assert property (
    auto_on |=> count == 4'h0 && !$rose(flag_reg)
  ) else $error("counter active under auto offset");

  count_floor_a: assert property (
    step && !any_zero && count == 4'h0 |=> count == 4'h0
  ) else $error("counter went below zero");

  zero_weight_a: assert property (
    $rose(flag_reg) |-> $past(weight_reg) != 4'h0
  ) else $error("flag raised with zero weight");

  flag_sticky_a: assert property (
    flag_reg && !flag_clr |=> flag_reg
  ) else $error("flag dropped without clear");

  flag_clear_a: assert property (
    flag_clr && !hit |=> !flag_reg
  ) else $error("write one did not clear flag");

  irq_follow_a: assert property (
    ##1 CALIB_IRQ_O == ($past(flag_reg) && $past(CTL_I.calib_irq_enable))
  ) else $error("interrupt does not track flag and enable");

  flag_rise_c:   cover property ($rose(flag_reg));
  flag_clear_c:  cover property (flag_reg ##1 flag_clr ##1 !flag_reg);
  set_wins_c:    cover property (hit && flag_clr);
  irq_c:         cover property ($rose(CALIB_IRQ_O));

endmodule

`default_nettype wire

/* inc/zwf_pkg.sv */
// Purpose: shared constants and carrier types for the zero reading weight filter
// Assumes: byte-wide register access from the serial register interface
// Notes:   register offsets are byte addresses of the device register map

package zwf_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ZWF_CFG3_ADDR   = 8'hdb;  // calibration_config_three
  localparam logic [7:0] ZWF_STAT_ADDR   = 8'hdc;  // calibration status
  localparam int         ZWF_WEIGHT_LSB  = 0;
  localparam int         ZWF_WEIGHT_W    = 4;
  localparam logic [3:0] ZWF_WEIGHT_RST  = 4'h0;
  localparam int         ZWF_ZFLAG_BIT   = 3;

  // ----------------------------------------------------------------
  // counter and channel figures
  // ----------------------------------------------------------------
  localparam logic [3:0] ZWF_CNT_LIMIT   = 4'hf;   // flag threshold, 15
  localparam logic [3:0] ZWF_CNT_RST     = 4'h0;
  localparam int         ZWF_NCH         = 4;
  localparam int         ZWF_ADC_W       = 14;

  // one finished conversion cycle of all four channels
  typedef struct packed {
    logic                                valid;
    logic [ZWF_NCH-1:0][ZWF_ADC_W-1:0]   ch;
  } zwf_conv_t;

  // one register access from the serial register interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } zwf_reg_req_t;

  // enables held in other registers of the device
  typedef struct packed {
    logic avg_auto_offset_fix;
    logic near_auto_offset_fix;
    logic calib_irq_enable;
  } zwf_ctl_t;

endpackage

/* testbench/tb_top.sv */
// Purpose: self-checking bench for the zero reading weight filter
// Assumes: design answers as the hand-over contract describes
// Notes:   a cycle model in the bench predicts every output each cycle
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import zwf_pkg::*;
  logic         REF_CLK_I = 1'b0;
  logic         RSTN_I    = 1'b0;
  logic         nop       = 1'b0;
  zwf_conv_t    conv      = '0;
  zwf_reg_req_t req       = '0;
  zwf_ctl_t     ctl       = '0;
  wire  [7:0]   rd_data;
  wire          rd_valid, zflag, irq;
  wire  [3:0]   zcount;
  int           err_total = 0;
  int           cmp_count = 0;
  integer       seed;
  logic [3:0]   m_w, m_cnt;
  logic         m_flag, m_irq, m_rv, hit;
  logic [7:0]   m_rd;
  logic [4:0]   sum;
  zwf_top zwf_top_i (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .NORMAL_OP_I(nop),
    .CONV_I(conv), .REG_I(req), .CTL_I(ctl), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid),
    .ZERO_FLAG_O(zflag), .CALIB_IRQ_O(irq), .ZERO_COUNT_O(zcount));
  // ----------------------------------------------------------------
  // clock, model and checks
  // ----------------------------------------------------------------
  always #5 REF_CLK_I = ~REF_CLK_I;
  // model sees pre-edge inputs, since the bench drives by nba
  always @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      {m_w, m_cnt, m_flag, m_irq, m_rv, m_rd} <= '0;
    end else begin
      hit = 1'b0;
      sum = m_cnt + m_w;
      if (ctl.avg_auto_offset_fix | ctl.near_auto_offset_fix) begin
        m_cnt <= 4'h0;
      end else if (conv.valid & nop) begin
        if (conv.ch[0] == 0 || conv.ch[1] == 0 || conv.ch[2] == 0 || conv.ch[3] == 0) begin
          hit = (m_w != 4'h0) && (sum >= 5'h0f);
          m_cnt <= (sum > 5'h0f) ? 4'hf : sum[3:0];
        end else if (m_cnt != 4'h0) begin
          m_cnt <= m_cnt - 4'h1;
        end
      end
      m_flag <= hit | (m_flag & ~(req.wr && req.addr == ZWF_STAT_ADDR && req.wdata[3]));
      m_irq  <= m_flag & ctl.calib_irq_enable;
      if (req.wr && req.addr == ZWF_CFG3_ADDR) m_w <= req.wdata[3:0];
      m_rv <= req.rd;
      m_rd <= !req.rd ? 8'h00 : (req.addr == ZWF_CFG3_ADDR) ? {4'h0, m_w} :
              (req.addr == ZWF_STAT_ADDR) ? {4'h0, m_flag, 3'b000} : 8'h00;
    end
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  // outputs settle well before the falling edge
  always @(negedge REF_CLK_I) begin
    if (RSTN_I) begin
      chk_byte({4'h0, zcount}, {4'h0, m_cnt});
      chk_bit(zflag, m_flag);
      chk_bit(irq, m_irq);
      chk_bit(rd_valid, m_rv);
      chk_byte(rd_data, m_rd);
    end
  end
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  task automatic drv(input logic v, input logic [3:0] zm, input logic r, input logic w,
                     input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge REF_CLK_I);
    conv.valid <= v;
    for (i = 0; i < 4; i++) conv.ch[i] <= zm[i] ? 14'h0000 : 14'(({$random(seed)} % 16383) + 1);
    req <= '{wr: w, rd: r, addr: a, wdata: d};
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #60000;
    err_total++;
    conclude();
  end
  initial begin
    int n;
    seed = 32'hfdddf342;
    repeat (2) @(posedge REF_CLK_I);
    RSTN_I <= 1'b1;
    nop <= 1'b1;
    ctl.calib_irq_enable <= 1'b1;
    drv(0, 4'h0, 1, 1, ZWF_CFG3_ADDR, 8'hff);
    drv(0, 4'h0, 1, 0, ZWF_CFG3_ADDR, 8'h00);
    drv(1, 4'h4, 0, 0, 8'h00, 8'h00);
    drv(1, 4'h0, 1, 0, ZWF_STAT_ADDR, 8'h00);
    drv(0, 4'h0, 0, 1, ZWF_STAT_ADDR, 8'hf7);
    drv(0, 4'h0, 0, 1, ZWF_STAT_ADDR, 8'h08);
    drv(1, 4'h1, 0, 1, ZWF_STAT_ADDR, 8'h08);
    drv(0, 4'h0, 1, 0, 8'h10, 8'h00);
    drv(0, 4'h0, 0, 1, ZWF_STAT_ADDR, 8'h08);
    // auto offset on, near then avg, while all channels read zero: count clears from 15 to zero and stays there
    ctl.near_auto_offset_fix <= 1'b1;
    repeat (3) drv(1, 4'hf, 0, 0, 8'h00, 8'h00);
    ctl <= '{avg_auto_offset_fix: 1'b1, near_auto_offset_fix: 1'b0, calib_irq_enable: 1'b1};
    repeat (3) drv(1, 4'hf, 0, 0, 8'h00, 8'h00);
    ctl.avg_auto_offset_fix <= 1'b0;
    drv(0, 4'h0, 0, 1, ZWF_STAT_ADDR, 8'h08);
    drv(0, 4'h0, 0, 1, ZWF_CFG3_ADDR, 8'h00);
    repeat (20) drv(1, 4'hf, 0, 0, 8'h00, 8'h00);
    for (n = 0; n < 3000; n++) begin
      drv($random(seed) % 4 != 0, ($random(seed) % 5 == 0) ? 4'($random(seed)) : 4'h0,
          $random(seed) % 6 == 0, $random(seed) % 25 == 0,
          ($random(seed) % 2 != 0) ? ZWF_CFG3_ADDR : ZWF_STAT_ADDR, 8'($random(seed)));
      nop <= ($random(seed) % 8 != 0);
      ctl <= '{avg_auto_offset_fix: $random(seed) % 40 == 0,
               near_auto_offset_fix: $random(seed) % 40 == 0,
               calib_irq_enable: $random(seed) % 3 != 0};
    end
    drv(0, 4'h0, 0, 0, 8'h00, 8'h00);
    repeat (2) @(posedge REF_CLK_I);
    conclude();
  end
endmodule
`default_nettype wire
